// >>> executor_defines.vh
// Function codes and fixed constants for the instruction executor
`ifndef EXECUTOR_DEFINES_VH
`define EXECUTOR_DEFINES_VH
// Numbered function codes (hex form of the decimal code)
`define FC_NO_OPERATION 8'h00
`define FC_INTERLOCK_BEGIN 8'h02
`define FC_INTERLOCK_CLOSE 8'h03
`define FC_LATCH 8'h0b
`define FC_UP_DOWN_COUNTER 8'h0c
`define FC_RISING_EDGE_PULSE 8'h0d
`define FC_FALLING_EDGE_PULSE 8'h0e
`define FC_WHOLE_WORD_SHIFT 8'h10
`define FC_WORD_COMPARE 8'h14
`define FC_COPY_WORD 8'h15
`define FC_COPY_INVERTED 8'h16
`define FC_DECIMAL_TO_RADIX2 8'h17
`define FC_RADIX2_TO_DECIMAL 8'h18
`define FC_ARITH_SHIFT_LEFT 8'h19
`define FC_ARITH_SHIFT_RIGHT 8'h1a
`define FC_ROTATE_LEFT_THROUGH_CARRY 8'h1b
`define FC_ROTATE_RIGHT_THROUGH_CARRY 8'h1c
`define FC_INVERT_IN_PLACE 8'h1d
`define FC_DECIMAL_ADD 8'h1e
`define FC_DECIMAL_SUBTRACT 8'h1f
`define FC_BITWISE_CONJUNCTION 8'h22
`define FC_BITWISE_DISJUNCTION 8'h23
`define FC_BITWISE_EXCLUSIVE_OR 8'h24
`define FC_BITWISE_EQUIVALENCE 8'h25
`define FC_DECIMAL_PLUS_ONE 8'h26
`define FC_DECIMAL_MINUS_ONE 8'h27
`define FC_CARRY_FORCE_ONE 8'h28
`define FC_CARRY_FORCE_ZERO 8'h29
`define FC_DIGIT_SHIFT_LEFT 8'h4a
`define FC_DIGIT_SHIFT_RIGHT 8'h4b
`define FC_NIBBLE_TO_ONEHOT 8'h4c
`define FC_HIGHEST_BIT_ENCODER 8'h4d
// Basic instructions carry no printed code; these are local codes
`define FC_OUTPUT_BIT 8'hf0
`define FC_OUTPUT_BIT_INVERTED 8'hf1
`define FC_CONDITIONAL_BIT_SET 8'hf2
`define FC_CONDITIONAL_BIT_CLEAR 8'hf3
`define FC_DELAY_TIMER 8'hf4
// Word and digit constants
`define WORD_ZERO 16'h0000
`define DIGIT_NINE 5'h09
`define DIGIT_ADJUST 5'h06
`define DIGIT_TEN 5'h0a
`define DECIMAL_LIMIT 16'h270f
`define WEIGHT_THOUSAND 16'h03e8
`define WEIGHT_HUNDRED 16'h0064
`define WEIGHT_TEN 16'h000a
`define NIBBLE_MASK 16'h000f
`endif

// >>> plc_instruction_executor.v
// Single-step execution unit for bit, word, decimal and range instructions
`timescale 1ns/100ps
//
// Operation
// - Code 34 ANDs two words; code 35 ORs them.
// - Code 36 sets bits where words differ; code 37 where they agree.
// - Code 21 copies source word or constant to destination unchanged.
// - Code 22 writes the inverted source word or constant to destination.
// - Code 23 converts decimal-coded to binary; code 24 binary back to decimal.
// - Codes 25/26 shift one word left/right; shifted-out bit enters carry.
// - Codes 27/28 rotate one word left/right through carry, seventeen-bit ring.
// - Code 29 inverts every bit of the addressed word in place.
// - Code 30 adds two decimal words plus carry, writing sum and carry.
// - Code 31 subtracts decimal word and carry from another decimal word.
// - Codes 38/39 add or subtract one, keeping decimal coding.
// - Code 40 forces carry to one; code 41 forces it to zero.
// - Code 20 compares two words, raising exactly one relation flag.
// - Codes 13/14 pulse the target bit for one scan on rise/fall.
// - Code 11 is a set/reset latch holding while both inputs idle.
// - Code 12 counts up/down on off-to-on changes of its inputs.
// - Code 16 shifts a word range one word toward end, zero at start.
// - Codes 74/75 shift a word range left/right by one digit.
// - Code 76 decodes a selected digit and sets that bit position.
// - Code 77 encodes the highest set bit position into a result digit.
// - Conditional clear/set change the bit only when the condition is on.
// - While interlocked: outputs off, timers reset, others idle, counters kept.
module plc_instruction_executor #(
  parameter SLOTS = 16,
  parameter SLOT_AW = 4,
  parameter RANGE_WORDS = 16,
  parameter RANGE_AW = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire exec_start,
  input wire [7:0] func_code,
  input wire imm_form,
  input wire exec_cond,
  input wire reset_in,
  input wire inc_in,
  input wire dec_in,
  input wire [SLOT_AW-1:0] slot_sel,
  input wire [15:0] src_a,
  input wire [15:0] src_b,
  input wire bit_in,
  input wire [1:0] digit_sel,
  input wire [RANGE_AW-1:0] range_start,
  input wire [RANGE_AW-1:0] range_end,
  input wire mem_wr_en,
  input wire [RANGE_AW-1:0] mem_addr,
  input wire [15:0] mem_wdata,
  output reg done_q,
  output reg [15:0] result_q,
  output reg result_we_q,
  output reg bit_q,
  output reg bit_we_q,
  output reg timer_reset_q,
  output reg carry_flag_q,
  output reg above_flag_q,
  output reg same_value_flag_q,
  output reg below_flag_q,
  output reg error_q,
  output reg interlocked_q,
  output reg [15:0] mem_rdata_q
);
`include "executor_defines.vh"

  ////////////////////////////////////////////////////////////////////////////////
  // Decimal and bit-position helpers
  function bcd_ok;
    input [15:0] v;
    integer k;
    begin
      bcd_ok = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        if ({1'b0, v[4*k +: 4]} > `DIGIT_NINE) begin
          bcd_ok = 1'b0;
        end
      end
    end
  endfunction

  // Sum of digits with carry chain; top bit is the carry out
  function [16:0] bcd_add;
    input [15:0] a;
    input [15:0] b;
    input cin;
    integer k;
    reg [4:0] s;
    reg c;
    begin
      c = cin;
      bcd_add = 17'h00000;
      for (k = 0; k < 4; k = k + 1) begin
        s = {1'b0, a[4*k +: 4]} + {1'b0, b[4*k +: 4]} + {4'h0, c};
        c = (s > `DIGIT_NINE);
        if (c) begin
          s = s + `DIGIT_ADJUST;
        end
        bcd_add[4*k +: 4] = s[3:0];
      end
      bcd_add[16] = c;
    end
  endfunction

  // Difference with borrow chain; a negative result wraps to ten's complement
  function [16:0] bcd_sub;
    input [15:0] a;
    input [15:0] b;
    input decimal_to_radix2;
    integer k;
    reg [4:0] s;
    reg br;
    begin
      br = decimal_to_radix2;
      bcd_sub = 17'h00000;
      for (k = 0; k < 4; k = k + 1) begin
        s = {1'b0, a[4*k +: 4]} - {1'b0, b[4*k +: 4]} - {4'h0, br};
        br = s[4];
        if (br) begin
          s = s + `DIGIT_TEN;
        end
        bcd_sub[4*k +: 4] = s[3:0];
      end
      bcd_sub[16] = br;
    end
  endfunction

  function [15:0] bcd_to_binary;
    input [15:0] v;
    begin
      bcd_to_binary = {12'h000, v[15:12]} * `WEIGHT_THOUSAND + {12'h000, v[11:8]} * `WEIGHT_HUNDRED
        + {12'h000, v[7:4]} * `WEIGHT_TEN + {12'h000, v[3:0]};
    end
  endfunction

  // Shift-and-add-three; caller rejects values above 9999
  function [15:0] binary_to_bcd;
    input [15:0] v;
    integer k;
    integer j;
    reg [31:0] sh;
    begin
      sh = {16'h0000, v};
      for (k = 0; k < 16; k = k + 1) begin
        for (j = 0; j < 4; j = j + 1) begin
          if (sh[16 + 4*j +: 4] > 4'h4) begin
            sh[16 + 4*j +: 4] = sh[16 + 4*j +: 4] + 4'h3;
          end
        end
        sh = {sh[30:0], 1'b0};
      end
      binary_to_bcd = sh[31:16];
    end
  endfunction

  function [3:0] highest_bit;
    input [15:0] v;
    integer k;
    begin
      highest_bit = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        if (v[k]) begin
          highest_bit = k[3:0];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State held across scans
  reg [15:0] mem_q [0:RANGE_WORDS-1];
  reg [15:0] count_q [0:SLOTS-1];
  reg [SLOTS-1:0] edge_prev_q;
  reg [SLOTS-1:0] inc_prev_q;
  reg [SLOTS-1:0] dec_prev_q;

  reg [15:0] result_d;
  reg result_we_d;
  reg bit_d;
  reg bit_we_d;
  reg timer_reset_d;
  reg carry_d;
  reg above_d;
  reg same_d;
  reg below_d;
  reg error_d;
  reg interlocked_d;
  reg edge_wr;
  reg count_wr;
  reg [15:0] count_d;
  reg [2:0] range_op;
  reg [16:0] wide;
  reg [3:0] nib;
  reg [15:0] dmask;
  wire run = exec_start & exec_cond;
  wire [15:0] count_now = count_q[slot_sel];
  wire [4:0] dsh = {1'b0, digit_sel, 2'b00};
  wire [RANGE_WORDS*16-1:0] mem_nx;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and execute one instruction per start strobe
  always @* begin
    result_d = result_q;
    result_we_d = 1'b0;
    bit_d = bit_q;
    bit_we_d = 1'b0;
    timer_reset_d = 1'b0;
    carry_d = carry_flag_q;
    above_d = above_flag_q;
    same_d = same_value_flag_q;
    below_d = below_flag_q;
    error_d = 1'b0;
    interlocked_d = interlocked_q;
    edge_wr = 1'b0;
    count_wr = 1'b0;
    count_d = count_now;
    range_op = 3'b000;
    wide = 17'h00000;
    nib = src_a[dsh[3:0] +: 4];
    dmask = `NIBBLE_MASK << dsh;
    if (exec_start && interlocked_q && func_code != `FC_INTERLOCK_BEGIN && func_code != `FC_INTERLOCK_CLOSE) begin
      case (func_code)
        `FC_OUTPUT_BIT, `FC_OUTPUT_BIT_INVERTED: begin
          bit_d = 1'b0;
          bit_we_d = 1'b1;
        end
        `FC_DELAY_TIMER: begin
          timer_reset_d = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (exec_start) begin
      // prefix form ignored here, both run alike
      case (func_code)
        `FC_INTERLOCK_BEGIN: begin
          interlocked_d = ~exec_cond;
        end
        `FC_INTERLOCK_CLOSE: begin
          interlocked_d = 1'b0;
        end
        `FC_OUTPUT_BIT: begin
          bit_d = exec_cond;
          bit_we_d = 1'b1;
        end
        `FC_OUTPUT_BIT_INVERTED: begin
          bit_d = ~exec_cond;
          bit_we_d = 1'b1;
        end
        `FC_CONDITIONAL_BIT_SET, `FC_CONDITIONAL_BIT_CLEAR: begin
          bit_d = (func_code == `FC_CONDITIONAL_BIT_SET);
          bit_we_d = exec_cond;
        end
        `FC_LATCH: begin
          bit_d = reset_in ? 1'b0 : (exec_cond | bit_in);
          bit_we_d = 1'b1;
        end
        `FC_RISING_EDGE_PULSE, `FC_FALLING_EDGE_PULSE: begin
          bit_d = (func_code == `FC_RISING_EDGE_PULSE) ? (exec_cond & ~edge_prev_q[slot_sel])
            : (~exec_cond & edge_prev_q[slot_sel]);
          bit_we_d = 1'b1;
          edge_wr = 1'b1;
        end
        `FC_UP_DOWN_COUNTER: begin
          count_wr = 1'b1;
          if (reset_in) begin
            count_d = `WORD_ZERO;
          end else if (inc_in && !inc_prev_q[slot_sel] && !(dec_in && !dec_prev_q[slot_sel])) begin
            wide = bcd_add(count_now, `WORD_ZERO, 1'b1);
            count_d = wide[15:0];
          end else if (dec_in && !dec_prev_q[slot_sel] && !(inc_in && !inc_prev_q[slot_sel])) begin
            wide = bcd_sub(count_now, `WORD_ZERO, 1'b1);
            count_d = wide[15:0];
          end
          result_d = count_d;
          result_we_d = 1'b1;
        end
        default: begin
          if (run) begin
            result_we_d = 1'b1;
            case (func_code)
              `FC_BITWISE_CONJUNCTION: result_d = src_a & src_b;
              `FC_BITWISE_DISJUNCTION: result_d = src_a | src_b;
              `FC_BITWISE_EXCLUSIVE_OR: result_d = src_a ^ src_b;
              `FC_BITWISE_EQUIVALENCE: result_d = ~(src_a ^ src_b);
              `FC_COPY_WORD: result_d = src_a;
              `FC_COPY_INVERTED: result_d = ~src_a;
              `FC_INVERT_IN_PLACE: result_d = ~src_a;
              `FC_DECIMAL_TO_RADIX2: begin
                result_d = bcd_to_binary(src_a);
                result_we_d = bcd_ok(src_a);
                error_d = ~bcd_ok(src_a);
              end
              `FC_RADIX2_TO_DECIMAL: begin
                result_d = binary_to_bcd(src_a);
                result_we_d = (src_a <= `DECIMAL_LIMIT);
                error_d = (src_a > `DECIMAL_LIMIT);
              end
              `FC_ARITH_SHIFT_LEFT: begin
                result_d = {src_a[14:0], 1'b0};
                carry_d = src_a[15];
              end
              `FC_ARITH_SHIFT_RIGHT: begin
                result_d = {1'b0, src_a[15:1]};
                carry_d = src_a[0];
              end
              `FC_ROTATE_LEFT_THROUGH_CARRY: begin
                result_d = {src_a[14:0], carry_flag_q};
                carry_d = src_a[15];
              end
              `FC_ROTATE_RIGHT_THROUGH_CARRY: begin
                result_d = {carry_flag_q, src_a[15:1]};
                carry_d = src_a[0];
              end
              `FC_DECIMAL_ADD, `FC_DECIMAL_SUBTRACT: begin
                wide = (func_code == `FC_DECIMAL_ADD) ? bcd_add(src_a, src_b, carry_flag_q)
                  : bcd_sub(src_a, src_b, carry_flag_q);
                result_d = wide[15:0];
                result_we_d = bcd_ok(src_a) & bcd_ok(src_b);
                error_d = ~(bcd_ok(src_a) & bcd_ok(src_b));
                carry_d = result_we_d ? wide[16] : carry_flag_q;
              end
              `FC_DECIMAL_PLUS_ONE, `FC_DECIMAL_MINUS_ONE: begin
                wide = (func_code == `FC_DECIMAL_PLUS_ONE) ? bcd_add(src_a, `WORD_ZERO, 1'b1)
                  : bcd_sub(src_a, `WORD_ZERO, 1'b1);
                result_d = wide[15:0];
                result_we_d = bcd_ok(src_a);
                error_d = ~bcd_ok(src_a);
              end
              `FC_CARRY_FORCE_ONE: begin
                carry_d = 1'b1;
                result_we_d = 1'b0;
              end
              `FC_CARRY_FORCE_ZERO: begin
                carry_d = 1'b0;
                result_we_d = 1'b0;
              end
              `FC_WORD_COMPARE: begin
                above_d = (src_a > src_b);
                same_d = (src_a == src_b);
                below_d = (src_a < src_b);
                result_we_d = 1'b0;
              end
              `FC_NIBBLE_TO_ONEHOT: result_d = 16'h0001 << nib;
              // highest set bit into chosen digit
              `FC_HIGHEST_BIT_ENCODER: begin
                result_d = (src_b & ~dmask) | ({12'h000, highest_bit(src_a)} << dsh);
                result_we_d = |src_a;
                error_d = ~|src_a;
              end
              `FC_WHOLE_WORD_SHIFT: begin
                range_op = 3'b001;
                result_we_d = 1'b0;
              end
              `FC_DIGIT_SHIFT_LEFT: begin
                range_op = 3'b010;
                result_we_d = 1'b0;
              end
              `FC_DIGIT_SHIFT_RIGHT: begin
                range_op = 3'b100;
                result_we_d = 1'b0;
              end
              default: result_we_d = 1'b0;
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next value of each range word; an empty range (start above end) is left alone
  genvar gi;
  generate
    for (gi = 0; gi < RANGE_WORDS; gi = gi + 1) begin : g_word
      wire [15:0] lower_w;
      wire [15:0] upper_w;
      wire in_range = (gi >= range_start) && (gi <= range_end);
      if (gi == 0) begin : g_first
        assign lower_w = `WORD_ZERO;
      end else begin : g_lower
        assign lower_w = mem_q[gi-1];
      end
      if (gi == RANGE_WORDS - 1) begin : g_last
        assign upper_w = `WORD_ZERO;
      end else begin : g_upper
        assign upper_w = mem_q[gi+1];
      end
      assign mem_nx[gi*16 +: 16] = !in_range ? mem_q[gi]
        : range_op[0] ? ((gi == range_start) ? `WORD_ZERO : lower_w)
        : range_op[1] ? {mem_q[gi][11:0], (gi == range_start) ? 4'h0 : lower_w[15:12]}
        : range_op[2] ? {(gi == range_end) ? 4'h0 : upper_w[3:0], mem_q[gi][15:4]}
        : mem_q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Registers; a range instruction beats a host word write in the same cycle
  integer i;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      result_q <= `WORD_ZERO;
      result_we_q <= 1'b0;
      bit_q <= 1'b0;
      bit_we_q <= 1'b0;
      timer_reset_q <= 1'b0;
      carry_flag_q <= 1'b0;
      above_flag_q <= 1'b0;
      same_value_flag_q <= 1'b0;
      below_flag_q <= 1'b0;
      error_q <= 1'b0;
      interlocked_q <= 1'b0;
      mem_rdata_q <= `WORD_ZERO;
      edge_prev_q <= {SLOTS{1'b0}};
      inc_prev_q <= {SLOTS{1'b0}};
      dec_prev_q <= {SLOTS{1'b0}};
      for (i = 0; i < RANGE_WORDS; i = i + 1) begin
        mem_q[i] <= `WORD_ZERO;
      end
      for (i = 0; i < SLOTS; i = i + 1) begin
        count_q[i] <= `WORD_ZERO;
      end
    end else begin
      done_q <= exec_start;
      result_q <= result_d;
      result_we_q <= result_we_d;
      bit_q <= bit_d;
      bit_we_q <= bit_we_d;
      timer_reset_q <= timer_reset_d;
      carry_flag_q <= carry_d;
      above_flag_q <= above_d;
      same_value_flag_q <= same_d;
      below_flag_q <= below_d;
      error_q <= error_d;
      interlocked_q <= interlocked_d;
      mem_rdata_q <= mem_q[mem_addr];
      if (edge_wr) begin
        edge_prev_q[slot_sel] <= exec_cond;
      end
      if (count_wr) begin
        count_q[slot_sel] <= count_d;
        inc_prev_q[slot_sel] <= inc_in;
        dec_prev_q[slot_sel] <= dec_in;
      end
      if (|range_op) begin
        for (i = 0; i < RANGE_WORDS; i = i + 1) begin
          mem_q[i] <= mem_nx[i*16 +: 16];
        end
      end else if (mem_wr_en) begin
        mem_q[mem_addr] <= mem_wdata;
      end
    end
  end

endmodule

// >>> executor_chk.sv
// Port-level assertions for the instruction executor
`timescale 1ns/100ps
`include "executor_defines.vh"
module executor_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire exec_start,
  input wire [7:0] func_code,
  input wire exec_cond,
  input wire [15:0] src_a,
  input wire [15:0] src_b,
  input wire done_q,
  input wire [15:0] result_q,
  input wire result_we_q,
  input wire carry_flag_q,
  input wire above_flag_q,
  input wire same_value_flag_q,
  input wire below_flag_q,
  input wire interlocked_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Word ops only count when enabled and outside an interlock
  wire word_go = exec_start && exec_cond && !interlocked_q;
  wire [7:0] fc = func_code;
  ////////////////////////////////////////////////////////////////
  property p_done; exec_start |=> done_q; endproperty
  a_done: assert property (p_done) else $error("done pulse missing");
  property p_idle; !exec_start |=> !done_q && !result_we_q; endproperty
  a_idle: assert property (p_idle) else $error("activity without a step");
  property p_and;
    word_go && fc == `FC_BITWISE_CONJUNCTION |=> result_we_q && result_q == ($past(src_a) & $past(src_b));
  endproperty
  a_and: assert property (p_and) else $error("conjunction wrong");
  property p_xnor;
    word_go && fc == `FC_BITWISE_EQUIVALENCE |=> result_q == ~($past(src_a) ^ $past(src_b));
  endproperty
  a_xnor: assert property (p_xnor) else $error("equivalence wrong");
  property p_move; word_go && fc == `FC_COPY_WORD |=> result_we_q && result_q == $past(src_a); endproperty
  a_move: assert property (p_move) else $error("copy wrong");
  property p_inv; word_go && fc == `FC_COPY_INVERTED |=> result_q == ~$past(src_a); endproperty
  a_inv: assert property (p_inv) else $error("inverted copy wrong");
  // Carry forced by the two carry codes, untouched by the disjunction code
  property p_carry;
    word_go && (fc == `FC_CARRY_FORCE_ONE || fc == `FC_CARRY_FORCE_ZERO)
      |=> carry_flag_q == ($past(func_code) == `FC_CARRY_FORCE_ONE);
  endproperty
  a_carry: assert property (p_carry) else $error("carry force wrong");
  property p_keep; word_go && fc == `FC_BITWISE_DISJUNCTION |=> $stable(carry_flag_q); endproperty
  a_keep: assert property (p_keep) else $error("carry moved by logic op");
  property p_cmp;
    word_go && fc == `FC_WORD_COMPARE |=> above_flag_q == ($past(src_a) > $past(src_b))
      && same_value_flag_q == ($past(src_a) == $past(src_b)) && below_flag_q == ($past(src_a) < $past(src_b));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  property p_lock; exec_start && interlocked_q && fc == `FC_COPY_WORD |=> !result_we_q; endproperty
  a_lock: assert property (p_lock) else $error("word written while interlocked");
endmodule
bind plc_instruction_executor executor_chk executor_chk_inst (.sys_clk, .rst_n, .exec_start, .func_code,
  .exec_cond, .src_a, .src_b, .done_q, .result_q, .result_we_q, .carry_flag_q, .above_flag_q,
  .same_value_flag_q, .below_flag_q, .interlocked_q);

// >>> tb.sv
// Self-checking bench for the instruction executor
`timescale 1ns/100ps
`include "executor_defines.vh"
module tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg exec_start = 1'b0;
  reg [7:0] func_code = 8'h00;
  reg imm_form = 1'b0;
  reg exec_cond = 1'b0;
  reg reset_in = 1'b0;
  reg inc_in = 1'b0;
  reg dec_in = 1'b0;
  reg [3:0] slot_sel = 4'h0;
  reg [15:0] src_a = 16'h0000;
  reg [15:0] src_b = 16'h0000;
  reg bit_in = 1'b0;
  reg [1:0] digit_sel = 2'h0;
  reg [3:0] range_start = 4'h0;
  reg [3:0] range_end = 4'h0;
  reg mem_wr_en = 1'b0;
  reg [3:0] mem_addr = 4'h0;
  reg [15:0] mem_wdata = 16'h0000;
  wire done_q, result_we_q, bit_q, bit_we_q, timer_reset_q, carry_flag_q, error_q, interlocked_q;
  wire above_flag_q, same_value_flag_q, below_flag_q;
  wire [15:0] result_q, mem_rdata_q;
  integer err_total = 0;
  integer num_checks = 0;
  plc_instruction_executor plc_instruction_executor_inst (.sys_clk, .rst_n, .exec_start, .func_code,
    .imm_form, .exec_cond, .reset_in, .inc_in, .dec_in, .slot_sel, .src_a, .src_b, .bit_in, .digit_sel,
    .range_start, .range_end, .mem_wr_en, .mem_addr, .mem_wdata, .done_q, .result_q, .result_we_q,
    .bit_q, .bit_we_q, .timer_reset_q, .carry_flag_q, .above_flag_q, .same_value_flag_q, .below_flag_q,
    .error_q, .interlocked_q, .mem_rdata_q);
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  // Comparisons of words and of single bits
  task cw(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cb(input got, input exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
    end
  endtask
  // One step after an idle edge, so a second call never raises the strobe as the first drops it
  task run(input [7:0] fc, input [15:0] a, input [15:0] b, input c);
    begin
      @(posedge sys_clk);
      #1;
      func_code = fc;
      src_a = a;
      src_b = b;
      exec_cond = c;
      exec_start = 1'b1;
      @(posedge sys_clk);
      #1;
      exec_start = 1'b0;
      imm_form = ~imm_form;
    end
  endtask
  task op(input [7:0] fc, input [15:0] a, input [15:0] b, input [15:0] e);
    begin
      run(fc, a, b, 1'b1);
      cb(result_we_q, 1'b1);
      cw(result_q, e);
    end
  endtask
  task cmpc(input [15:0] a, input [15:0] b, input g, input q, input l);
    begin
      run(`FC_WORD_COMPARE, a, b, 1'b1);
      cb(above_flag_q, g);
      cb(same_value_flag_q, q);
      cb(below_flag_q, l);
    end
  endtask
  // Range memory host port: write, and read one cycle late
  task wm(input [3:0] ad, input [15:0] d);
    begin
      mem_addr = ad;
      mem_wdata = d;
      mem_wr_en = 1'b1;
      @(posedge sys_clk);
      #1;
      mem_wr_en = 1'b0;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task rm(input [3:0] ad, input [15:0] e);
    begin
      mem_addr = ad;
      @(posedge sys_clk);
      #1;
      cw(mem_rdata_q, e);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog well beyond the roughly 125 cycles the sequence needs
  initial begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    op(`FC_BITWISE_CONJUNCTION, 16'h00f0, 16'h0ff0, 16'h00f0);
    op(`FC_BITWISE_DISJUNCTION, 16'h00f0, 16'h0ff0, 16'h0ff0);
    op(`FC_BITWISE_EXCLUSIVE_OR, 16'h00f0, 16'h0ff0, 16'h0f00);
    op(`FC_BITWISE_EQUIVALENCE, 16'h00f0, 16'h0ff0, 16'hf0ff);
    op(`FC_COPY_WORD, 16'h1234, 16'h0000, 16'h1234);
    op(`FC_COPY_INVERTED, 16'h1234, 16'h0000, 16'hedcb);
    op(`FC_DECIMAL_TO_RADIX2, 16'h1234, 16'h0000, 16'h04d2);
    op(`FC_RADIX2_TO_DECIMAL, 16'h04d2, 16'h0000, 16'h1234);
    // A non-decimal digit is refused with no write
    run(`FC_DECIMAL_TO_RADIX2, 16'h000a, 16'h0000, 1'b1);
    cb(error_q, 1'b1);
    cb(result_we_q, 1'b0);
    op(`FC_ARITH_SHIFT_LEFT, 16'h8001, 16'h0000, 16'h0002);
    cb(carry_flag_q, 1'b1);
    op(`FC_ARITH_SHIFT_RIGHT, 16'h0002, 16'h0000, 16'h0001);
    cb(carry_flag_q, 1'b0);
    run(`FC_CARRY_FORCE_ONE, 16'h0000, 16'h0000, 1'b1);
    cb(carry_flag_q, 1'b1);
    op(`FC_ROTATE_LEFT_THROUGH_CARRY, 16'h8000, 16'h0000, 16'h0001);
    cb(carry_flag_q, 1'b1);
    run(`FC_CARRY_FORCE_ZERO, 16'h0000, 16'h0000, 1'b1);
    cb(carry_flag_q, 1'b0);
    op(`FC_ROTATE_RIGHT_THROUGH_CARRY, 16'h0001, 16'h0000, 16'h0000);
    cb(carry_flag_q, 1'b1);
    op(`FC_INVERT_IN_PLACE, 16'h00ff, 16'h0000, 16'hff00);
    // Decimal arithmetic with carry in and out
    op(`FC_DECIMAL_ADD, 16'h0999, 16'h0001, 16'h1001);
    cb(carry_flag_q, 1'b0);
    op(`FC_DECIMAL_ADD, 16'h9999, 16'h0001, 16'h0000);
    cb(carry_flag_q, 1'b1);
    op(`FC_DECIMAL_SUBTRACT, 16'h1000, 16'h0000, 16'h0999);
    cb(carry_flag_q, 1'b0);
    op(`FC_DECIMAL_SUBTRACT, 16'h0000, 16'h0001, 16'h9999);
    cb(carry_flag_q, 1'b1);
    op(`FC_DECIMAL_PLUS_ONE, 16'h0999, 16'h0000, 16'h1000);
    op(`FC_DECIMAL_MINUS_ONE, 16'h1000, 16'h0000, 16'h0999);
    cmpc(16'h8000, 16'h0001, 1'b1, 1'b0, 1'b0);
    cmpc(16'h4321, 16'h4321, 1'b0, 1'b1, 1'b0);
    cmpc(16'h0001, 16'hffff, 1'b0, 1'b0, 1'b1);
    op(`FC_NIBBLE_TO_ONEHOT, 16'h0005, 16'h0000, 16'h0020);
    op(`FC_HIGHEST_BIT_ENCODER, 16'h0100, 16'h0000, 16'h0008);
    // Edge pulses last one step only
    slot_sel = 4'h3;
    run(`FC_RISING_EDGE_PULSE, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b1);
    run(`FC_RISING_EDGE_PULSE, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b0);
    slot_sel = 4'h4;
    run(`FC_FALLING_EDGE_PULSE, 16'h0000, 16'h0000, 1'b1);
    run(`FC_FALLING_EDGE_PULSE, 16'h0000, 16'h0000, 1'b0);
    cb(bit_q, 1'b1);
    // Latch sets, holds with both inputs idle, then resets
    run(`FC_LATCH, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b1);
    bit_in = 1'b1;
    run(`FC_LATCH, 16'h0000, 16'h0000, 1'b0);
    cb(bit_q, 1'b1);
    reset_in = 1'b1;
    run(`FC_LATCH, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b0);
    reset_in = 1'b0;
    // Counter moves only on a rising increment or decrement input
    slot_sel = 4'h5;
    inc_in = 1'b1;
    run(`FC_UP_DOWN_COUNTER, 16'h0000, 16'h0000, 1'b1);
    cw(result_q, 16'h0001);
    run(`FC_UP_DOWN_COUNTER, 16'h0000, 16'h0000, 1'b1);
    cw(result_q, 16'h0001);
    inc_in = 1'b0;
    dec_in = 1'b1;
    run(`FC_UP_DOWN_COUNTER, 16'h0000, 16'h0000, 1'b1);
    cw(result_q, 16'h0000);
    dec_in = 1'b0;
    run(`FC_CONDITIONAL_BIT_SET, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b1);
    run(`FC_CONDITIONAL_BIT_CLEAR, 16'h0000, 16'h0000, 1'b0);
    cb(bit_we_q, 1'b0);
    run(`FC_CONDITIONAL_BIT_CLEAR, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b0);
    run(8'h2a, 16'h1234, 16'h0000, 1'b1);
    cb(done_q, 1'b1);
    cb(result_we_q, 1'b0);
    // Interlocked section: outputs off, timer reset, words idle
    run(`FC_INTERLOCK_BEGIN, 16'h0000, 16'h0000, 1'b0);
    cb(interlocked_q, 1'b1);
    run(`FC_COPY_WORD, 16'h5555, 16'h0000, 1'b1);
    cb(result_we_q, 1'b0);
    run(`FC_OUTPUT_BIT, 16'h0000, 16'h0000, 1'b1);
    cb(bit_q, 1'b0);
    run(`FC_DELAY_TIMER, 16'h0000, 16'h0000, 1'b1);
    cb(timer_reset_q, 1'b1);
    run(`FC_INTERLOCK_CLOSE, 16'h0000, 16'h0000, 1'b1);
    cb(interlocked_q, 1'b0);
    // Word range shift over memory words 0 to 2, digit shifts over words 1 to 2
    wm(4'h0, 16'h1111);
    wm(4'h1, 16'h2222);
    wm(4'h2, 16'h3333);
    range_end = 4'h2;
    run(`FC_WHOLE_WORD_SHIFT, 16'h0000, 16'h0000, 1'b1);
    rm(4'h0, 16'h0000);
    rm(4'h1, 16'h1111);
    rm(4'h2, 16'h2222);
    range_start = 4'h1;
    run(`FC_DIGIT_SHIFT_LEFT, 16'h0000, 16'h0000, 1'b1);
    rm(4'h1, 16'h1110);
    rm(4'h2, 16'h2221);
    run(`FC_DIGIT_SHIFT_RIGHT, 16'h0000, 16'h0000, 1'b1);
    rm(4'h1, 16'h1111);
    rm(4'h2, 16'h0222);
    finish_test;
  end
endmodule
